// ---- nip_pkg.sv ----
// Constants and state encodings for the nested interrupt priority block.
// Assumes a single 40 MHz clock and a 32-bit AXI4-Lite register slave.
package nip_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_PRIO0  = 8'h00;
    localparam logic [7:0] OFF_PRIO1  = 8'h04;
    localparam logic [7:0] OFF_PRIO2  = 8'h08;
    localparam logic [7:0] OFF_PRIO3  = 8'h0c;
    localparam logic [7:0] OFF_SENSE  = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;

    // Reset values
    localparam logic [7:0] RST_PRIO  = 8'hff;
    localparam logic [7:0] RST_SENSE = 8'h00;
    localparam logic [3:0] PRIO3_RO  = 4'hf;
    localparam logic [14:0] RST_PINS = 15'h7fff;

    // Level codes, high bit then low bit
    localparam logic [1:0] LVL_0 = 2'b10;
    localparam logic [1:0] LVL_1 = 2'b01;
    localparam logic [1:0] LVL_2 = 2'b00;
    localparam logic [1:0] LVL_3 = 2'b11;

    // Sensitivity field positions
    localparam int SENSE_B_LSB  = 6;
    localparam int INV_B_BIT    = 5;
    localparam int SENSE_AF_LSB = 3;
    localparam int INV_A_BIT    = 2;
    localparam logic [7:0] SENSE_WMASK = 8'hfc;

    // Sensitivity codes
    localparam logic [1:0] SNS_FALL_LOW = 2'b00;
    localparam logic [1:0] SNS_RISE     = 2'b01;
    localparam logic [1:0] SNS_FALL     = 2'b10;
    localparam logic [1:0] SNS_BOTH     = 2'b11;

    // Vector numbers in hardware priority order
    localparam int NUM_VEC      = 14;
    localparam int VEC_TIMEBASE = 1;
    localparam int VEC_EXT0     = 2;
    localparam int VEC_SPI      = 7;
    localparam int VEC_TIMER_A  = 8;
    localparam int VEC_TIMER_B  = 9;
    localparam int VEC_SERIAL   = 10;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ---- nip_ctrl.sv ----
// Nested interrupt controller with external pin sensitivity logic.
// Assumes a CPU core that pulses instruction strobes and acks vectors,
// and port pins synchronous to ref_clk_i.
// Operation
// - Four 8-bit priority registers reset to FFh; top nibble of fourth reads ones.
// - Each maskable vector owns one 2-bit pair, pair 0 at the top vector.
// - Stored pairs use the same level encoding as the current level.
// - Encoding 10 level 0, 01 level 1, 00 level 2, 11 level 3.
// - Writing pattern 10 into a pair keeps its old value.
// - Reset or trap service sets the current level to 11.
// - Pair raised during own service re-enters if still pending.
// - Enable, wait, halt load 10; disable, trap load 11; return, pop restore.
// - Two branch flags: level equals 11, and level differs from 11.
// - Level instructions inside a routine change the level until next change.
// - Hardware priority descends by vector number; 0, 6 and 11 to 13 unused.
// - Only reset, external groups and serial peripheral wake from halt.
// - Active-halt wakes on reset, time base; others only on mask parts.
// - Setting an external group pair to 11 clears its pending latch.
// - Bits 7:6 pick group B sensitivity: fall+low, rise, fall, both.
// - Bit 5 inverts the group B low-half sensitivity only.
// - Bits 4:3 pick groups A and F sensitivity with the same codes.
// - Bit 2 inverts group A sensitivity; group F never inverted.
// - Sensitivity register resets to 00h; bits 1:0 stay cleared.
// - Highest software level served first, ties by hardware order.
// - Edge requests are latched and cleared when their routine starts.
// - Enabled pins of one group, or of one half of group B, are ORed into one request.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module nip_ctrl
    import nip_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        rstn_i,
    input  wire logic [7:0]  awaddr_i,
    input  wire logic        awvalid_i,
    output logic             awready_o,
    input  wire logic [31:0] wdata_i,
    input  wire logic [3:0]  wstrb_i,
    input  wire logic        wvalid_i,
    output logic             wready_o,
    output logic [1:0]       bresp_o,
    output logic             bvalid_o,
    input  wire logic        bready_i,
    input  wire logic [7:0]  araddr_i,
    input  wire logic        arvalid_i,
    output logic             arready_o,
    output logic [31:0]      rdata_o,
    output logic [1:0]       rresp_o,
    output logic             rvalid_o,
    input  wire logic        rready_i,
    input  wire logic        irq_enable_instr_i,
    input  wire logic        irq_disable_instr_i,
    input  wire logic        wait_for_irq_instr_i,
    input  wire logic        halt_instr_i,
    input  wire logic        trap_instr_i,
    input  wire logic        reset_vec_i,
    input  wire logic        irq_return_instr_i,
    input  wire logic        pop_cc_i,
    input  wire logic [1:0]  stacked_level_i,
    input  wire logic        irq_ack_i,
    output logic             irq_req_o,
    output logic [3:0]       irq_vec_o,
    output logic [1:0]       current_level_o,
    output logic             branch_if_masked_o,
    output logic             branch_if_unmasked_o,
    output logic             wake_halt_o,
    output logic             wake_active_halt_o,
    input  wire logic        time_base_irq_i,
    input  wire logic        spi_irq_i,
    input  wire logic        timer_a_irq_i,
    input  wire logic        timer_b_irq_i,
    input  wire logic        async_serial_irq_i,
    input  wire logic [3:0]  port_a_i,
    input  wire logic [2:0]  port_f_i,
    input  wire logic [7:0]  port_b_i,
    input  wire logic [14:0] pin_irq_en_i,
    input  wire logic        mask_rom_part_i
);

    typedef struct packed {
        logic [7:0]  pr0;
        logic [7:0]  pr1;
        logic [7:0]  pr2;
        logic [7:0]  pr3;
        logic [7:0]  sense;
        logic [1:0]  lvl;
        logic [3:0]  ext_lat;
        logic [14:0] pins;
        logic        aw_hold;
        logic        w_hold;
        logic [7:0]  waddr;
        logic [7:0]  wbyte;
        logic        wstrb0;
        logic        awrdy;
        logic        wrdy;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arrdy;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [7:0]  rbyte;
        logic        req;
        logic [3:0]  vec;
        logic        masked;
        logic        unmasked;
        logic        wake_h;
        logic        wake_ah;
        logic        rom_part;
        logic        strap_done;
    } nip_state_t;

    nip_state_t s_r;
    nip_state_t s_nxt;

    logic [31:0]         prio_all;
    logic [NUM_VEC-1:0]  pend;
    logic [3:0]          hit;
    logic                found;
    logic [1:0]          best_rank;
    logic [3:0]          best_vec;
    logic                do_wr;
    logic [1:0]          ack_lvl;
    logic [15:0]         pr_ext_nxt;

    // Level codes ordered 10 < 01 < 00 < 11
    function automatic logic [1:0] lvl_rank(input logic [1:0] c);
        return {c[1] ~^ c[0], c[0]};
    endfunction

    // Pattern 10 in a pair keeps the stored pair
    function automatic logic [7:0] prio_merge(input logic [7:0] old_v,
                                              input logic [7:0] new_v);
        logic [7:0] r;
        r = new_v;
        for (int k = 0; k < 4; k++) begin
            if (new_v[2*k +: 2] == LVL_0) begin
                r[2*k +: 2] = old_v[2*k +: 2];
            end
        end
        return r;
    endfunction

    // Inversion flips pin polarity, turning falling into rising and low into high
    function automatic logic ext_hit(input logic [7:0] cur,
                                     input logic [7:0] prv,
                                     input logic [7:0] en,
                                     input logic [1:0] mode,
                                     input logic       inv);
        logic [7:0] c;
        logic [7:0] p;
        logic       fall;
        logic       rise;
        logic       low;
        c    = cur ^ {8{inv}};
        p    = prv ^ {8{inv}};
        fall = |(p & ~c & en);
        rise = |(~p & c & en);
        low  = |(~c & en);
        unique case (mode)
            SNS_FALL_LOW: ext_hit = fall | low;
            SNS_RISE:     ext_hit = rise;
            SNS_FALL:     ext_hit = fall;
            SNS_BOTH:     ext_hit = rise | fall;
        endcase
    endfunction

    // Pin events per external group
    always_comb begin
        hit[0] = ext_hit({4'h0, port_a_i}, {4'h0, s_r.pins[3:0]},
                         {4'h0, pin_irq_en_i[3:0]},
                         s_r.sense[SENSE_AF_LSB +: 2], s_r.sense[INV_A_BIT]);
        hit[1] = ext_hit({5'h00, port_f_i}, {5'h00, s_r.pins[6:4]},
                         {5'h00, pin_irq_en_i[6:4]},
                         s_r.sense[SENSE_AF_LSB +: 2], 1'b0);
        hit[2] = ext_hit({4'h0, port_b_i[3:0]}, {4'h0, s_r.pins[10:7]},
                         {4'h0, pin_irq_en_i[10:7]},
                         s_r.sense[SENSE_B_LSB +: 2], s_r.sense[INV_B_BIT]);
        hit[3] = ext_hit({4'h0, port_b_i[7:4]}, {4'h0, s_r.pins[14:11]},
                         {4'h0, pin_irq_en_i[14:11]},
                         s_r.sense[SENSE_B_LSB +: 2], 1'b0);
    end

    // Pending sources in vector order; peripheral flags latch themselves
    always_comb begin
        prio_all = {s_r.pr3, s_r.pr2, s_r.pr1, s_r.pr0};
        pend = '0;
        pend[VEC_TIMEBASE] = time_base_irq_i;
        pend[VEC_EXT0 +: 4] = s_r.ext_lat;
        pend[VEC_SPI] = spi_irq_i;
        pend[VEC_TIMER_A] = timer_a_irq_i;
        pend[VEC_TIMER_B] = timer_b_irq_i;
        pend[VEC_SERIAL] = async_serial_irq_i;
        ack_lvl = prio_all[2*s_r.vec +: 2];
    end

    // Arbitration: strict compare on ascending number keeps hardware order
    always_comb begin
        logic [1:0] pr;
        pr = LVL_3;
        found = 1'b0;
        best_rank = 2'b00;
        best_vec = 4'h0;
        for (int v = 0; v < NUM_VEC; v++) begin
            pr = prio_all[2*v +: 2];
            if (pend[v] && pr != LVL_3 && lvl_rank(pr) > lvl_rank(s_r.lvl)
                && (!found || lvl_rank(pr) > best_rank)) begin
                found = 1'b1;
                best_rank = lvl_rank(pr);
                best_vec = v[3:0];
            end
        end
    end

    // Next-state logic: bus slave, registers, level, latches, outputs
    always_comb begin
        s_nxt = s_r;
        do_wr = s_r.aw_hold && s_r.w_hold && !s_r.bvalid;

        // Write address and data may arrive in either order
        if (awvalid_i && s_r.awrdy) begin
            s_nxt.aw_hold = 1'b1;
            s_nxt.waddr = awaddr_i;
        end
        if (wvalid_i && s_r.wrdy) begin
            s_nxt.w_hold = 1'b1;
            s_nxt.wbyte = wdata_i[7:0];
            s_nxt.wstrb0 = wstrb_i[0];
        end
        if (bvalid_o && bready_i) begin
            s_nxt.bvalid = 1'b0;
        end
        if (do_wr) begin
            s_nxt.aw_hold = 1'b0;
            s_nxt.w_hold = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = RESP_OKAY;
            unique case (s_r.waddr)
                OFF_PRIO0: begin
                    if (s_r.wstrb0) s_nxt.pr0 = prio_merge(s_r.pr0, s_r.wbyte);
                end
                OFF_PRIO1: begin
                    if (s_r.wstrb0) s_nxt.pr1 = prio_merge(s_r.pr1, s_r.wbyte);
                end
                OFF_PRIO2: begin
                    if (s_r.wstrb0) s_nxt.pr2 = prio_merge(s_r.pr2, s_r.wbyte);
                end
                OFF_PRIO3: begin
                    if (s_r.wstrb0) begin
                        s_nxt.pr3 = prio_merge(s_r.pr3, s_r.wbyte);
                        s_nxt.pr3[7:4] = PRIO3_RO;
                    end
                end
                OFF_SENSE: begin
                    // Silently ignored outside level 3 so live edges never glitch
                    if (s_r.wstrb0 && s_r.lvl == LVL_3) begin
                        s_nxt.sense = s_r.wbyte & SENSE_WMASK;
                    end
                end
                OFF_STATUS: begin
                    s_nxt.bresp = RESP_OKAY;
                end
                default: s_nxt.bresp = RESP_SLVERR;
            endcase
        end
        s_nxt.awrdy = !s_nxt.aw_hold && !s_nxt.bvalid;
        s_nxt.wrdy = !s_nxt.w_hold && !s_nxt.bvalid;

        // Read channel, one outstanding read
        if (rvalid_o && rready_i) begin
            s_nxt.rvalid = 1'b0;
        end
        if (arvalid_i && s_r.arrdy) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = RESP_OKAY;
            unique case (araddr_i)
                OFF_PRIO0:  s_nxt.rbyte = s_r.pr0;
                OFF_PRIO1:  s_nxt.rbyte = s_r.pr1;
                OFF_PRIO2:  s_nxt.rbyte = s_r.pr2;
                OFF_PRIO3:  s_nxt.rbyte = s_r.pr3;
                OFF_SENSE:  s_nxt.rbyte = s_r.sense;
                OFF_STATUS: s_nxt.rbyte = {s_r.lvl, s_r.req, 1'b0, s_r.ext_lat};
                default: begin
                    s_nxt.rbyte = 8'h00;
                    s_nxt.rresp = RESP_SLVERR;
                end
            endcase
        end
        s_nxt.arrdy = !s_nxt.rvalid;

        // Current level; non-maskable entry outranks everything
        if (trap_instr_i || reset_vec_i) begin
            s_nxt.lvl = LVL_3;
        end else if (irq_ack_i) begin
            s_nxt.lvl = ack_lvl;
        end else if (irq_return_instr_i || pop_cc_i) begin
            s_nxt.lvl = stacked_level_i;
        end else if (irq_enable_instr_i || wait_for_irq_instr_i
                     || halt_instr_i) begin
            s_nxt.lvl = LVL_0;
        end else if (irq_disable_instr_i) begin
            s_nxt.lvl = LVL_3;
        end

        // External group pairs as they will stand after this edge
        pr_ext_nxt = {s_nxt.pr1, s_nxt.pr0};

        // External latches: ack clears, a new event in the same cycle wins
        for (int g = 0; g < 4; g++) begin
            if (irq_ack_i && s_r.vec == 4'(VEC_EXT0 + g)) begin
                s_nxt.ext_lat[g] = 1'b0;
            end
            if (hit[g]) begin
                s_nxt.ext_lat[g] = 1'b1;
            end
            // Disabling a group drops whatever it had pending
            if (pr_ext_nxt[2*(VEC_EXT0+g) +: 2] == LVL_3) begin
                s_nxt.ext_lat[g] = 1'b0;
            end
        end
        s_nxt.pins = {port_b_i, port_f_i, port_a_i};

        // Strap caught once after reset release
        if (!s_r.strap_done) begin
            s_nxt.rom_part = mask_rom_part_i;
            s_nxt.strap_done = 1'b1;
        end

        // Registered outputs; request drops the cycle after the ack cycle to avoid a double take
        s_nxt.req = found && !irq_ack_i;
        s_nxt.vec = best_vec;
        s_nxt.masked = (s_nxt.lvl == LVL_3);
        s_nxt.unmasked = (s_nxt.lvl != LVL_3);
        s_nxt.wake_h = |{pend[VEC_EXT0 +: 4], pend[VEC_SPI]};
        s_nxt.wake_ah = pend[VEC_TIMEBASE]
                        | (s_r.rom_part & s_nxt.wake_h);
    end

    // State register
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_r <= '0;
            s_r.pr0 <= RST_PRIO;
            s_r.pr1 <= RST_PRIO;
            s_r.pr2 <= RST_PRIO;
            s_r.pr3 <= RST_PRIO;
            s_r.sense <= RST_SENSE;
            s_r.lvl <= LVL_3;
            s_r.pins <= RST_PINS;
            s_r.masked <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Ports straight from flops
    assign awready_o = s_r.awrdy;
    assign wready_o = s_r.wrdy;
    assign bvalid_o = s_r.bvalid;
    assign bresp_o = s_r.bresp;
    assign arready_o = s_r.arrdy;
    assign rvalid_o = s_r.rvalid;
    assign rresp_o = s_r.rresp;
    assign rdata_o = {24'h000000, s_r.rbyte};
    assign irq_req_o = s_r.req;
    assign irq_vec_o = s_r.vec;
    assign current_level_o = s_r.lvl;
    assign branch_if_masked_o = s_r.masked;
    assign branch_if_unmasked_o = s_r.unmasked;
    assign wake_halt_o = s_r.wake_h;
    assign wake_active_halt_o = s_r.wake_ah;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    chk_prio3_top_ones: assert property (s_r.pr3[7:4] == PRIO3_RO)
        else $error("upper nibble of fourth priority register not ones");
    chk_level0_kept: assert property (
        do_wr && s_r.waddr == OFF_PRIO0 && s_r.wstrb0
        && s_r.wbyte[1:0] == LVL_0 |=> $stable(s_r.pr0[1:0]))
        else $error("pattern 10 overwrote a priority pair");
    chk_trap_level3: assert property (
        trap_instr_i |=> current_level_o == LVL_3)
        else $error("trap did not load level 3");
    chk_enable_level0: assert property (
        irq_enable_instr_i && !trap_instr_i && !reset_vec_i && !irq_ack_i
        && !irq_return_instr_i && !pop_cc_i |=> current_level_o == LVL_0)
        else $error("enable instruction did not load level 0");
    chk_branch_pair: assert property (
        branch_if_masked_o == (current_level_o == LVL_3)
        && branch_if_unmasked_o != branch_if_masked_o)
        else $error("branch flags disagree with level");
    chk_sense_locked: assert property (
        do_wr && s_r.waddr == OFF_SENSE && s_r.lvl != LVL_3
        |=> $stable(s_r.sense))
        else $error("sensitivity written outside level 3");
    chk_disabled_clear: assert property (
        s_r.pr0[5:4] == LVL_3 |-> s_r.ext_lat[0] == 1'b0)
        else $error("disabled group still pending");
    chk_ack_loads: assert property (
        irq_ack_i && !trap_instr_i && !reset_vec_i
        |=> current_level_o == $past(ack_lvl))
        else $error("ack did not load the vector level");
    chk_halt_wake: assert property (
        s_r.ext_lat == 4'h0 && !spi_irq_i |=> !wake_halt_o)
        else $error("halt wake without a capable source");
    chk_active_wake: assert property (
        !s_r.rom_part && !time_base_irq_i |=> !wake_active_halt_o)
        else $error("flash part woke from active-halt");

    cov_ack_ext: cover property (irq_req_o && irq_ack_i && irq_vec_o == 4'h2);
    cov_sense_wr: cover property (do_wr && s_r.waddr == OFF_SENSE
                                  && s_r.lvl == LVL_3);
    cov_trap: cover property (trap_instr_i ##1 current_level_o == LVL_3);
    cov_wake: cover property (wake_active_halt_o && s_r.rom_part);

endmodule

// ---- nip_cpu_model.sv ----
// CPU core stand-in: acknowledges whichever vector the controller requests.
// Assumes the controller's request outputs and one shared 40 MHz clock.
`timescale 1ns/10ps
module nip_cpu_model (
    input  wire logic       ref_clk_i,
    input  wire logic       rstn_i,
    input  wire logic       slow_i,
    input  wire logic       irq_req_i,
    input  wire logic [3:0] irq_vec_i,
    output logic            irq_ack_o,
    output logic [3:0]      last_vec_o,
    output logic [7:0]      ack_cnt_o
);
    logic [2:0] wait_r;

    // Ack only while a request stands; slow mode lets it stand a few cycles first
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_ack_o  <= 1'b0;
            last_vec_o <= 4'h0;
            ack_cnt_o  <= 8'h00;
            wait_r     <= 3'h0;
        end else begin
            irq_ack_o <= 1'b0;
            if (irq_req_i && !irq_ack_o) begin
                wait_r <= wait_r + 3'h1;
                if (!slow_i || wait_r == 3'h3) begin
                    irq_ack_o  <= 1'b1;
                    last_vec_o <= irq_vec_i;
                    ack_cnt_o  <= ack_cnt_o + 8'h01;
                    wait_r     <= 3'h0;
                end
            end
        end
    end
endmodule

// ---- nested_irq_priority_and_ext_sense_bench.sv ----
// Self-checking bench for the nested interrupt controller.
// Assumes the controller's AXI4-Lite slave timing and a CPU stand-in model.
`timescale 1ns/10ps
module nested_irq_priority_and_ext_sense_bench;
    import nip_pkg::*;
    logic        clk = 1'b0, rstn = 1'b0, slow = 1'b0, rom = 1'b0;
    logic [1:0]  wresp;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, ins = 8'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0]  stk = 2'b10, bresp, rresp, lvl;
    logic [4:0]  per = 5'h00;
    logic [3:0]  port_a = 4'hf, vec, last_vec;
    logic [2:0]  port_f = 3'h7;
    logic [7:0]  port_b = 8'hff, ack_cnt, rd;
    logic [14:0] pin_en = 15'h0000;
    logic        awready, wready, bvalid, arready, rvalid, ack, req, msk, umsk, wk_h, wk_a;
    int          error_cnt = 0, checks = 0;

    always #12.5 clk = ~clk;

    nip_ctrl uut (.ref_clk_i(clk), .rstn_i(rstn), .awaddr_i(awaddr), .awvalid_i(awvalid),
        .awready_o(awready), .wdata_i(wdata), .wstrb_i(4'h1), .wvalid_i(wvalid),
        .wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid), .bready_i(bready),
        .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready), .rdata_o(rdata),
        .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready), .irq_enable_instr_i(ins[0]),
        .irq_disable_instr_i(ins[1]), .wait_for_irq_instr_i(ins[2]), .halt_instr_i(ins[3]),
        .trap_instr_i(ins[4]), .reset_vec_i(ins[5]), .irq_return_instr_i(ins[6]),
        .pop_cc_i(ins[7]), .stacked_level_i(stk), .irq_ack_i(ack), .irq_req_o(req),
        .irq_vec_o(vec), .current_level_o(lvl), .branch_if_masked_o(msk),
        .branch_if_unmasked_o(umsk), .wake_halt_o(wk_h), .wake_active_halt_o(wk_a),
        .time_base_irq_i(per[0]), .spi_irq_i(per[1]), .timer_a_irq_i(per[2]),
        .timer_b_irq_i(per[3]), .async_serial_irq_i(per[4]), .port_a_i(port_a),
        .port_f_i(port_f), .port_b_i(port_b), .pin_irq_en_i(pin_en), .mask_rom_part_i(rom));

    nip_cpu_model cpu (.ref_clk_i(clk), .rstn_i(rstn), .slow_i(slow), .irq_req_i(req),
        .irq_vec_i(vec), .irq_ack_o(ack), .last_vec_o(last_vec), .ack_cnt_o(ack_cnt));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Address and data offered together, each released at its own taking edge
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        wresp = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata[7:0];
        r = rresp;
        rready <= 1'b0;
    endtask

    // One-cycle instruction strobe; level settles one edge later
    task automatic pulse(input int i, input logic [1:0] s);
        @(posedge clk);
        ins <= 8'(32'h1 << i); stk <= s;
        @(posedge clk);
        ins <= 8'h00;
        @(negedge clk);
    endtask

    task automatic wait_acks(input logic [7:0] n);
        for (int k = 0; k < 50 && ack_cnt !== n; k++) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic t_regs();
        logic [1:0] r;
        for (int i = 0; i < 4; i++) begin
            axi_rd(8'(4 * i), rd, r);
            chk(rd, 8'hff);
        end
        axi_rd(OFF_SENSE, rd, r);
        chk(rd, 8'h00);
        axi_rd(8'h20, rd, r);
        chk({rd, r}, {8'h00, RESP_SLVERR});
        axi_wr(8'h20, 8'h55);
        chk(wresp, RESP_SLVERR);
        axi_wr(OFF_PRIO1, 8'hcf);
        axi_wr(OFF_PRIO1, 8'h64);
        chk(wresp, RESP_OKAY);
        axi_rd(OFF_PRIO1, rd, r);
        chk(rd, 8'h44);
        axi_wr(OFF_PRIO1, 8'hff);
        axi_wr(OFF_PRIO3, 8'h00);
        axi_rd(OFF_PRIO3, rd, r);
        chk(rd, 8'hf0);
    endtask

    // One peripheral request at a time; a flash part has no mask-ROM wake sources
    task automatic t_wake();
        for (int i = 0; i < 5; i++) begin
            @(posedge clk) per <= 5'(32'h1 << i);
            repeat (3) @(posedge clk);
            chk(wk_h, i == 1);
            chk(wk_a, i == 0);
        end
        @(posedge clk) per <= 5'h00;
    endtask

    task automatic t_instr();
        int         seq [8] = '{0, 1, 2, 4, 3, 5, 7, 6};
        logic [1:0] exp [8] = '{2'b10, 2'b11, 2'b10, 2'b11, 2'b10, 2'b11, 2'b01, 2'b00};
        for (int i = 0; i < 8; i++) begin
            pulse(seq[i], exp[i]);
            chk(lvl, exp[i]);
            chk({msk, umsk}, {exp[i] == LVL_3, exp[i] != LVL_3});
        end
    endtask

    task automatic t_sense();
        logic [1:0] r;
        pulse(1, 2'b00);
        axi_wr(OFF_SENSE, 8'hff);
        axi_rd(OFF_SENSE, rd, r);
        chk(rd, 8'hfc);
        pulse(0, 2'b00);
        axi_wr(OFF_SENSE, 8'h00);
        axi_rd(OFF_SENSE, rd, r);
        chk(rd, 8'hfc);
        pulse(1, 2'b00);
        axi_wr(OFF_SENSE, 8'h10);
        axi_rd(OFF_SENSE, rd, r);
        chk(rd, 8'h10);
    endtask

    // Group A falling edge at level 2 against a level-1 time base request
    task automatic t_nest();
        logic [1:0] r;
        axi_wr(OFF_PRIO0, 8'hc7);
        axi_rd(OFF_PRIO0, rd, r);
        chk(rd, 8'hc7);
        // Slow acks let the pin latch, one cycle behind the time base, win first
        @(posedge clk) begin
            pin_en <= 15'h0001;
            slow <= 1'b1;
        end
        pulse(0, 2'b00);
        @(posedge clk) begin
            port_a <= 4'he;
            per <= 5'h01;
        end
        wait_acks(8'h01);
        chk(last_vec, 4'h2);
        chk(lvl, LVL_2);
        @(posedge clk) port_a <= 4'hf;
        pulse(6, LVL_0);
        wait_acks(8'h02);
        chk(last_vec, 4'h1);
        chk(lvl, LVL_1);
        @(posedge clk) per <= 5'h00;
    endtask

    // Inverted group B low half: a high pin latches at level 3; disabling drops it
    task automatic t_pins();
        logic [1:0] r;
        pulse(1, 2'b00);
        axi_wr(OFF_SENSE, 8'h20);
        axi_wr(OFF_PRIO1, 8'hfc);
        @(posedge clk) pin_en <= 15'h0080;
        repeat (3) @(posedge clk);
        axi_rd(OFF_STATUS, rd, r);
        chk(rd, 8'hc4);
        axi_wr(OFF_PRIO1, 8'hff);
        axi_rd(OFF_STATUS, rd, r);
        chk(rd, 8'hc0);
    endtask

    // Mask-ROM strap, caught after a second reset, adds the serial peripheral wake
    task automatic t_rom();
        @(posedge clk) begin
            rstn <= 1'b0;
            rom <= 1'b1;
        end
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        per <= 5'h02;
        repeat (3) @(posedge clk);
        chk(wk_a, 1'b1);
        per <= 5'h00;
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        t_regs();
        t_wake();
        t_instr();
        t_sense();
        t_nest();
        t_pins();
        t_rom();
        end_sim();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        end_sim();
    end
endmodule
